// >>> hdl/sbfp_defines.vh
// constants of the sdlc bit and frame processor
`ifndef SBFP_DEFINES_VH
`define SBFP_DEFINES_VH
// ==========================================
// register byte offsets
`define SBFP_OFS_CTRL 8'h00
`define SBFP_OFS_STAT 8'h04
`define SBFP_OFS_TXD 8'h08
`define SBFP_OFS_RXD 8'h0C
`define SBFP_OFS_PORT3 8'h10
// ==========================================
// control bit positions and reset values
`define SBFP_CTRL_NO_FCS 0
`define SBFP_CTRL_NO_CTL 1
`define SBFP_CTRL_AUTO 2
`define SBFP_CTRL_TX_EN 3
`define SBFP_CTRL_RX_EN 4
`define SBFP_CTRL_NRZI 5
`define SBFP_CTRL_RST 6'h00
`define SBFP_PORT3_RST 2'h3
// ==========================================
// status bit positions; sticky bits cleared by writing one
`define SBFP_ST_RXV 0
`define SBFP_ST_FCS 1
`define SBFP_ST_END 2
`define SBFP_ST_ABORT 3
`define SBFP_ST_GA 4
`define SBFP_ST_EGA 5
`define SBFP_ST_SHUT 6
`define SBFP_ST_OVR 7
`define SBFP_ST_BUSY 8
`define SBFP_ST_HOLD 9
`define SBFP_ST_UNDR 10
`define SBFP_ST_ODD 11
`define SBFP_ST_DIAG 12
`define SBFP_ST_W1C 13'h0CFC
// ==========================================
// field tags of received bytes
`define SBFP_FLD_ADDR 2'h0
`define SBFP_FLD_CTL 2'h1
`define SBFP_FLD_INFO 2'h2
// ==========================================
// line patterns and counts
`define SBFP_CRC_POLY 16'h1021
`define SBFP_CRC_PRESET 16'hFFFF
`define SBFP_FLAG_BYTE 8'h7E
`define SBFP_STUFF_ONES 3'h5
`define SBFP_FLAG_ONES 3'h6
`define SBFP_SHUT_ZEROS 3'h7
`endif

// >>> hdl/sbfp_fcs.v
// bit-serial frame check register, x^16 + x^12 + x^5 + 1
`timescale 1ns/1ps
`default_nettype none
`include "sbfp_defines.vh"
module sbfp_fcs (
  // clock and reset
  input wire ref_clk,
  input wire nrst,
  // control and data
  input wire init,
  input wire en,
  input wire bit_in,
  // state
  output reg [15:0] crc_r
);
  // ==========================================
  // shift register
  always @(posedge ref_clk) begin
    if (!nrst) begin
      crc_r <= `SBFP_CRC_PRESET;
    end else if (init) begin
      crc_r <= `SBFP_CRC_PRESET;
    end else if (en) begin
      crc_r <= {crc_r[14:0], 1'b0} ^ ((crc_r[15] ^ bit_in) ? `SBFP_CRC_POLY : 16'h0000);
    end
  end
endmodule // sbfp_fcs
`default_nettype wire

// >>> hdl/sbfp_top.v
// sdlc bit and frame processor with avalon-mm register slave
// Summary of operation
// - all three format bits zero or auto only: flag, address, control, info, check, flag.
// - no-control bit drops control; address also dropped unless auto mode set.
// - no-check bit: no check sequence sent nor checked, any address option.
// - frame content handled in whole bytes only; odd bit counts flagged.
// - nrzi compares current and previous bit on both directions.
// - shifter serialises outgoing bytes and assembles incoming bytes.
// - zeros inserted on transmit, deleted on receive, to hide control patterns.
// - receiver recognises flag, go-ahead and abort patterns.
// - five ones then zero outside a frame reported as early go-ahead.
// - three-bit counter finds eight zeros as shutoff; a one clears it.
// - check register preset to all ones before each frame, both ways.
// - check error raises no interrupt; cleared by next opening flag.
// - byte side holds cpu registers and the frame sequencing machine.
// - writing zero to port bit one latch enters diagnostic mode.
// - diagnostic: port bit zero feeds receive; each port write pulses clock.
// - diagnostic: transmit data readable on port bit one, per write pulse.
// - diagnostic: transmit pin released to high impedance (txd_oe low); no other pin has a drive enable.
// - check polynomial x16+x12+x5+1 over address, control and information.
// - external clock: sample receive on rising, shift transmit on falling.
`timescale 1ns/1ps
`default_nettype none
`include "sbfp_defines.vh"
module sbfp_top (
  // clock and reset
  input wire ref_clk,
  input wire nrst,
  // avalon-mm slave
  input wire [7:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  output reg [31:0] avs_readdata,
  output reg avs_waitrequest,
  // serial link
  input wire sclk_in,
  input wire rxd_in,
  output reg txd_out,
  output reg txd_oe
);
  localparam TX_IDLE = 3'h0;
  localparam TX_FLAG = 3'h1;
  localparam TX_DATA = 3'h2;
  localparam TX_FCS = 3'h3;
  localparam TX_CLOSE = 3'h4;
  localparam [7:0] FLAG_PAT = `SBFP_FLAG_BYTE;

  function [1:0] field_of;
    input [1:0] idx;
    input no_ctl;
    input auto;
    begin
      // fields that remain for each format
      if (no_ctl && !auto) begin
        field_of = `SBFP_FLD_INFO;
      end else if (idx == 2'h0) begin
        field_of = `SBFP_FLD_ADDR;
      end else if (idx == 2'h1 && !no_ctl) begin
        field_of = `SBFP_FLD_CTL;
      end else begin
        field_of = `SBFP_FLD_INFO;
      end
    end
  endfunction

  // ==========================================
  // pin synchronisers
  reg [2:0] sclk_sy_r;
  reg [2:0] rxd_sy_r;
  reg sclk_st_r;
  reg rxd_st_r;
  wire sclk_ok = sclk_sy_r[2] == sclk_sy_r[1];
  wire sclk_rise = sclk_ok && sclk_sy_r[1] && !sclk_st_r;
  wire sclk_fall = sclk_ok && !sclk_sy_r[1] && sclk_st_r;
  always @(posedge ref_clk) begin
    if (!nrst) begin
      // link clock idles high, so reset to that level or a false rise follows reset
      sclk_sy_r <= 3'h7;
      rxd_sy_r <= 3'h0;
      sclk_st_r <= 1'b1;
      rxd_st_r <= 1'b0;
    end else begin
      sclk_sy_r <= {sclk_sy_r[1:0], sclk_in};
      rxd_sy_r <= {rxd_sy_r[1:0], rxd_in};
      if (sclk_ok) begin
        sclk_st_r <= sclk_sy_r[1];
      end
      if (rxd_sy_r[2] == rxd_sy_r[1]) begin
        rxd_st_r <= rxd_sy_r[1];
      end
    end
  end

  // ==========================================
  // bus slave and registers
  reg [5:0] ctrl_r;
  reg [1:0] port3_r;
  reg p3_pulse_r;
  reg [12:0] stat_r;
  reg [10:0] rxd_r;
  reg [8:0] hold_r;
  reg hold_full_r;
  reg [31:0] rd_mux;
  wire wr_go = avs_write && !avs_waitrequest;
  wire rd_go = avs_read && !avs_waitrequest;
  wire no_fcs = ctrl_r[`SBFP_CTRL_NO_FCS];
  // diagnostic when port bit one latch is zero
  wire diag = !port3_r[1];
  wire wr_ctrl = wr_go && avs_address == `SBFP_OFS_CTRL;
  wire wr_stat = wr_go && avs_address == `SBFP_OFS_STAT;
  wire wr_txd = wr_go && avs_address == `SBFP_OFS_TXD;
  wire wr_p3 = wr_go && avs_address == `SBFP_OFS_PORT3;
  wire rd_rxd = rd_go && avs_address == `SBFP_OFS_RXD;
  // each port write gives one clock pulse
  wire rx_tick = diag ? p3_pulse_r : (sclk_rise && ctrl_r[`SBFP_CTRL_RX_EN]);
  // transmit moves on the falling edge
  wire tx_tick = diag ? p3_pulse_r : sclk_fall;
  wire rx_raw = diag ? port3_r[0] : rxd_st_r;

  // receive and transmit event terms, driven below
  reg rx_b, rx_flag, rx_seven, rx_early, rx_content, rx_byte, rx_deliver;
  reg rx_close, rx_fcs_bad, rx_odd, rx_shut;
  reg [7:0] rx_byte_val, rx_dbyte;
  reg tx_load, tx_undr;
  reg [2:0] tx_state_r;

  always @* begin
    rd_mux = 32'h0000_0000;
    case (avs_address)
      `SBFP_OFS_CTRL: rd_mux[5:0] = ctrl_r;
      `SBFP_OFS_STAT: rd_mux[12:0] = stat_r;
      `SBFP_OFS_TXD: rd_mux[8:0] = hold_r;
      `SBFP_OFS_RXD: rd_mux[10:0] = rxd_r;
      // transmit line level seen on bit one
      `SBFP_OFS_PORT3: rd_mux[1:0] = {txd_out, port3_r[0]};
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  always @(posedge ref_clk) begin
    if (!nrst) begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h0000_0000;
      ctrl_r <= `SBFP_CTRL_RST;
      port3_r <= `SBFP_PORT3_RST;
      p3_pulse_r <= 1'b0;
      hold_r <= 9'h000;
      hold_full_r <= 1'b0;
    end else begin
      // one wait cycle per access, so read data are stable when it drops
      avs_waitrequest <= !((avs_read || avs_write) && avs_waitrequest);
      if (avs_read && avs_waitrequest) begin
        avs_readdata <= rd_mux;
      end
      p3_pulse_r <= wr_p3;
      if (wr_ctrl) begin
        ctrl_r <= avs_writedata[5:0];
      end
      if (wr_p3) begin
        port3_r <= avs_writedata[1:0];
      end
      if (wr_txd) begin
        hold_r <= avs_writedata[8:0];
        hold_full_r <= 1'b1;
      end else if (tx_load) begin
        hold_full_r <= 1'b0;
      end
    end
  end

  // ==========================================
  // receive bit processor
  reg rx_prev_r, rx_hunt_r, rx_bdone_r;
  reg [2:0] rx_ones_r, rx_zeros_r, rx_bcnt_r;
  reg [7:0] rx_sh_r, rx_pipe0_r, rx_pipe1_r;
  reg [1:0] rx_nbytes_r, rx_didx_r;
  reg [15:0] rx_snap_r;
  wire [15:0] rx_crc;

  always @* begin
    rx_b = ctrl_r[`SBFP_CTRL_NRZI] ? !(rx_raw ^ rx_prev_r) : rx_raw;
    // flag, go-ahead and abort from the ones count
    rx_flag = rx_tick && !rx_b && rx_ones_r == `SBFP_FLAG_ONES;
    rx_seven = rx_tick && rx_b && rx_ones_r == `SBFP_FLAG_ONES;
    rx_early = rx_tick && !rx_b && rx_ones_r == `SBFP_STUFF_ONES && rx_hunt_r;
    // zero after five ones is dropped
    rx_content = rx_tick && !rx_hunt_r &&
                 (rx_b ? rx_ones_r < `SBFP_FLAG_ONES : rx_ones_r < `SBFP_STUFF_ONES);
    rx_byte = rx_content && rx_bcnt_r == 3'h7;
    rx_byte_val = {rx_b, rx_sh_r[7:1]};
    // without check field bytes pass straight through
    rx_deliver = rx_byte && (no_fcs || rx_nbytes_r >= 2'h2);
    rx_dbyte = no_fcs ? rx_byte_val : rx_pipe1_r;
    rx_close = rx_flag && !rx_hunt_r && rx_nbytes_r != 2'h0;
    // closing flag off a byte boundary
    rx_odd = rx_close && rx_bcnt_r != 3'h7;
    rx_fcs_bad = rx_close && !rx_odd && !no_fcs && (rx_nbytes_r < 2'h2 || rx_snap_r != 16'h0000);
    rx_shut = rx_tick && !rx_b && rx_zeros_r == `SBFP_SHUT_ZEROS;
  end

  always @(posedge ref_clk) begin
    if (!nrst) begin
      rx_prev_r <= 1'b0;
      rx_hunt_r <= 1'b1;
      rx_bdone_r <= 1'b0;
      rx_ones_r <= 3'h0;
      rx_zeros_r <= 3'h0;
      rx_bcnt_r <= 3'h0;
      rx_sh_r <= 8'h00;
      rx_pipe0_r <= 8'h00;
      rx_pipe1_r <= 8'h00;
      rx_nbytes_r <= 2'h0;
      rx_didx_r <= 2'h0;
      rx_snap_r <= 16'h0000;
      rxd_r <= 11'h000;
    end else begin
      // flag bits enter the check register too, so the value at the byte edge is kept
      rx_bdone_r <= rx_byte;
      if (rx_bdone_r) begin
        rx_snap_r <= rx_crc;
      end
      if (rx_tick) begin
        rx_prev_r <= rx_raw;
        // zero counter cleared by a one
        if (rx_b) begin
          rx_zeros_r <= 3'h0;
        end else if (rx_zeros_r != `SBFP_SHUT_ZEROS) begin
          rx_zeros_r <= rx_zeros_r + 3'h1;
        end
        if (!rx_b) begin
          rx_ones_r <= 3'h0;
        end else if (rx_ones_r != 3'h7) begin
          rx_ones_r <= rx_ones_r + 3'h1;
        end
      end
      if (rx_seven) begin
        rx_hunt_r <= 1'b1;
      end
      if (rx_flag) begin
        rx_hunt_r <= 1'b0;
        rx_bcnt_r <= 3'h0;
        rx_nbytes_r <= 2'h0;
        rx_didx_r <= 2'h0;
      end else if (rx_content) begin
        rx_sh_r <= rx_byte_val;
        rx_bcnt_r <= rx_bcnt_r + 3'h1;
        if (rx_byte) begin
          rx_pipe0_r <= rx_byte_val;
          rx_pipe1_r <= rx_pipe0_r;
          if (rx_nbytes_r != 2'h3) begin
            rx_nbytes_r <= rx_nbytes_r + 2'h1;
          end
        end
      end
      if (rx_deliver) begin
        rxd_r <= {field_of(rx_didx_r, ctrl_r[`SBFP_CTRL_NO_CTL], ctrl_r[`SBFP_CTRL_AUTO]), 1'b0, rx_dbyte};
        if (rx_didx_r != 2'h2) begin
          rx_didx_r <= rx_didx_r + 2'h1;
        end
      end
    end
  end

  // receive check preset at every flag
  sbfp_fcs u_rx_fcs (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .init(rx_flag),
    .en(rx_content),
    .bit_in(rx_b),
    .crc_r(rx_crc)
  );

  // ==========================================
  // transmit frame sequencer
  reg [3:0] tx_cnt_r;
  reg [7:0] tx_sh_r;
  reg [2:0] tx_ones_r;
  reg tx_last_r, tx_bit, tx_stuff, tx_crc_en, tx_crc_init, tx_body;
  wire [15:0] tx_crc;

  always @* begin
    tx_body = tx_state_r == TX_DATA || tx_state_r == TX_FCS;
    // stuffing after five content ones, also just ahead of the closing flag
    tx_stuff = (tx_body || tx_state_r == TX_CLOSE) && tx_ones_r == `SBFP_STUFF_ONES;
    case (tx_state_r)
      TX_IDLE: tx_bit = 1'b1;
      TX_FLAG: tx_bit = FLAG_PAT[tx_cnt_r[2:0]];
      TX_DATA: tx_bit = tx_stuff ? 1'b0 : tx_sh_r[0];
      TX_FCS: tx_bit = tx_stuff ? 1'b0 : tx_crc[15];
      TX_CLOSE: tx_bit = tx_stuff ? 1'b0 : FLAG_PAT[tx_cnt_r[2:0]];
      default: tx_bit = 1'b1;
    endcase
    tx_crc_en = tx_tick && tx_body && !tx_stuff;
    tx_crc_init = tx_tick && tx_state_r == TX_IDLE;
    tx_load = tx_tick && !tx_stuff && tx_cnt_r[2:0] == 3'h7 && hold_full_r &&
              (tx_state_r == TX_FLAG || (tx_state_r == TX_DATA && !tx_last_r));
    tx_undr = tx_tick && !tx_stuff && tx_state_r == TX_DATA && tx_cnt_r[2:0] == 3'h7 &&
              !tx_last_r && !hold_full_r;
  end

  always @(posedge ref_clk) begin
    if (!nrst) begin
      tx_state_r <= TX_IDLE;
      tx_cnt_r <= 4'h0;
      tx_sh_r <= 8'h00;
      tx_ones_r <= 3'h0;
      tx_last_r <= 1'b0;
      txd_out <= 1'b1;
      txd_oe <= 1'b0;
    end else begin
      txd_oe <= !diag;
      if (tx_tick) begin
        txd_out <= ctrl_r[`SBFP_CTRL_NRZI] ? (tx_bit ? txd_out : !txd_out) : tx_bit;
        if (tx_stuff || !tx_body) begin
          tx_ones_r <= 3'h0;
        end else begin
          tx_ones_r <= tx_bit ? tx_ones_r + 3'h1 : 3'h0;
        end
        if (!tx_stuff) begin
          tx_cnt_r <= tx_cnt_r + 4'h1;
        end
        if (tx_load) begin
          tx_sh_r <= hold_r[7:0];
          tx_last_r <= hold_r[8];
        end else if (tx_state_r == TX_DATA && !tx_stuff) begin
          // lsb first out of the byte
          tx_sh_r <= {1'b0, tx_sh_r[7:1]};
        end
        case (tx_state_r)
          TX_IDLE: begin
            tx_cnt_r <= 4'h0;
            if (ctrl_r[`SBFP_CTRL_TX_EN] && hold_full_r) begin
              tx_state_r <= TX_FLAG;
            end
          end
          TX_FLAG: begin
            if (tx_cnt_r[2:0] == 3'h7) begin
              tx_cnt_r <= 4'h0;
              tx_state_r <= TX_DATA;
            end
          end
          TX_DATA: begin
            if (!tx_stuff && tx_cnt_r[2:0] == 3'h7) begin
              tx_cnt_r <= 4'h0;
              if (tx_last_r || !hold_full_r) begin
                tx_state_r <= no_fcs ? TX_CLOSE : TX_FCS;
              end
            end
          end
          TX_FCS: begin
            if (!tx_stuff && tx_cnt_r == 4'hF) begin
              tx_cnt_r <= 4'h0;
              tx_state_r <= TX_CLOSE;
            end
          end
          TX_CLOSE: begin
            if (tx_cnt_r[2:0] == 3'h7) begin
              tx_state_r <= TX_IDLE;
            end
          end
          default: tx_state_r <= TX_IDLE;
        endcase
      end
    end
  end

  // in the check state the register shifts itself out
  sbfp_fcs u_tx_fcs (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .init(tx_crc_init),
    .en(tx_crc_en),
    .bit_in(tx_state_r == TX_FCS ? tx_crc[15] : tx_sh_r[0]),
    .crc_r(tx_crc)
  );

  // ==========================================
  // status; a set in the clearing cycle wins
  always @(posedge ref_clk) begin
    if (!nrst) begin
      stat_r <= 13'h0000;
    end else begin
      if (wr_stat) begin
        stat_r <= stat_r & ~(avs_writedata[12:0] & `SBFP_ST_W1C);
      end
      if (rd_rxd) begin
        stat_r[`SBFP_ST_RXV] <= 1'b0;
      end
      if (rx_deliver) begin
        stat_r[`SBFP_ST_RXV] <= 1'b1;
        if (stat_r[`SBFP_ST_RXV] && !rd_rxd) begin
          stat_r[`SBFP_ST_OVR] <= 1'b1;
        end
      end
      // status only, cleared by the next opening flag
      if (rx_fcs_bad) begin
        stat_r[`SBFP_ST_FCS] <= 1'b1;
      end else if (rx_flag && rx_nbytes_r == 2'h0) begin
        stat_r[`SBFP_ST_FCS] <= 1'b0;
      end
      if (rx_close) begin
        stat_r[`SBFP_ST_END] <= 1'b1;
      end
      if (rx_odd) begin
        stat_r[`SBFP_ST_ODD] <= 1'b1;
      end
      if (rx_seven && !rx_hunt_r) begin
        stat_r[`SBFP_ST_ABORT] <= 1'b1;
      end
      if (rx_seven && rx_hunt_r) begin
        stat_r[`SBFP_ST_GA] <= 1'b1;
      end
      if (rx_early) begin
        stat_r[`SBFP_ST_EGA] <= 1'b1;
      end
      if (rx_shut) begin
        stat_r[`SBFP_ST_SHUT] <= 1'b1;
      end
      if (tx_undr) begin
        stat_r[`SBFP_ST_UNDR] <= 1'b1;
      end
      stat_r[`SBFP_ST_BUSY] <= tx_state_r != TX_IDLE;
      stat_r[`SBFP_ST_HOLD] <= hold_full_r;
      stat_r[`SBFP_ST_DIAG] <= diag;
    end
  end
endmodule // sbfp_top
`default_nettype wire

// >>> dv/sbfp_remote.sv
// remote station model: link clock, receive data and transmit capture
`timescale 1ns/1ps
`default_nettype none
module sbfp_remote (
  // link towards the unit
  output logic sclk,
  output logic rxd,
  // transmit pin level as seen on the wire
  input wire logic txd_wire
);
  bit q_out[$];
  bit q_in[$];
  initial begin
    sclk = 1'b1;
    rxd = 1'b1;
  end
  // ==========
  // one burst of link clock
  // clock runs n bits, ones once the queue is empty, data on fall
  task automatic run(input int n, input bit nrzi);
    bit b;
    #137;
    for (int i = 0; i < n; i++) begin
      // the unit answers some ref clocks after a fall, so its bit is taken just before the next one
      q_in.push_back(txd_wire);
      b = (q_out.size() > 0) ? q_out.pop_front() : 1'b1;
      sclk = 1'b0;
      rxd = nrzi ? (b ? rxd : !rxd) : b;
      #400;
      sclk = 1'b1;
      #400;
    end
  endtask
endmodule // sbfp_remote
`default_nettype wire

// >>> dv/sbfp_top_monitor.sv
// port checker for the sdlc bit and frame processor
`timescale 1ns/1ps
`default_nettype none
`include "sbfp_defines.vh"
module sbfp_top_monitor (
  // clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  // avalon-mm slave
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  // serial link
  input wire logic sclk_in,
  input wire logic rxd_in,
  input wire logic txd_out,
  input wire logic txd_oe
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!nrst);
  logic [5:0] ctrl_r;
  wire logic rd_done = avs_read && !avs_waitrequest;
  wire logic wr_done = avs_write && !avs_waitrequest;
  wire logic mapped = (avs_address[1:0] == 2'b00) && (avs_address <= 8'h10);
  wire logic p3_wr = wr_done && (avs_address == `SBFP_OFS_PORT3);
  // ==========
  // shadow of the control register
  always @(posedge ref_clk) begin
    if (!nrst) begin
      ctrl_r <= 6'h00;
    end else if (wr_done && avs_address == `SBFP_OFS_CTRL) begin
      ctrl_r <= avs_writedata[5:0];
    end
  end
  // ==========
  // bus handshake
  sequence s_req;
    (avs_read || avs_write) && avs_waitrequest;
  endsequence
  sequence s_ack_once;
    !avs_waitrequest ##1 avs_waitrequest;
  endsequence
  a_wait_one_cycle: assert property (s_req |=> s_ack_once)
    else $error("waitrequest not low for exactly one cycle");
  a_no_idle_ack: assert property (!(avs_read || avs_write) |=> avs_waitrequest)
    else $error("answer without a request");
  a_unmapped_zero: assert property (rd_done && !mapped |-> avs_readdata == 32'h0000_0000)
    else $error("unmapped read not zero");
  a_ctrl_readback: assert property (rd_done && avs_address == `SBFP_OFS_CTRL |-> avs_readdata == {26'h000_0000, ctrl_r})
    else $error("control readback differs from last write");
  // ==========
  // reset and pin drive
  a_reset_line_idle: assert property ($rose(nrst) |-> txd_out && !txd_oe && avs_waitrequest)
    else $error("outputs not at reset levels");
  a_oe_after_reset: assert property ($rose(nrst) |=> txd_oe)
    else $error("pin not driven after reset");
  a_diag_pin_off: assert property (p3_wr && !avs_writedata[1] |=> ##[0:1] !txd_oe)
    else $error("pin still driven in diagnostic mode");
  a_normal_pin_on: assert property (p3_wr && avs_writedata[1] |=> ##[0:1] txd_oe)
    else $error("pin not driven outside diagnostic mode");
  a_txd_after_fall: assert property ($changed(txd_out) |-> !txd_oe || !$past(txd_oe) || !$past(sclk_in, 3)
    || !$past(sclk_in, 4) || !$past(sclk_in, 5))
    else $error("transmit line moved without a link clock fall");
endmodule // sbfp_top_monitor
bind sbfp_top sbfp_top_monitor mon_u (
  .ref_clk(ref_clk), .nrst(nrst), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .sclk_in(sclk_in), .rxd_in(rxd_in), .txd_out(txd_out), .txd_oe(txd_oe)
);
`default_nettype wire

// >>> dv/sbfp_top_test.sv
// self-checking bench for the sdlc bit and frame processor
`timescale 1ns/1ps
`default_nettype none
`include "sbfp_defines.vh"
module sbfp_top_test;
  typedef struct {logic [7:0] ctrl; logic [7:0] d; bit bad; logic [10:0] rx;} sbfp_row_t;
  logic ref_clk = 1'b0;
  logic nrst = 1'b0;
  logic [7:0] avs_address = 8'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0000_0000;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic txd_out;
  logic txd_oe;
  wire logic sclk_in;
  wire logic rxd_in;
  // the pin has a pull-up, so a released line reads high
  wire logic txd_wire = txd_oe ? txd_out : 1'b1;
  int n_fail = 0;
  int n_compared = 0;
  int ones;
  bit fr[$];
  logic [15:0] crc;
  logic [31:0] rd;
  logic [7:0] rst_a[7] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'hFC};
  logic [31:0] rst_v[7] = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h3, 32'h0, 32'h0};
  sbfp_row_t rows[9] = '{
    '{8'h10, 8'hAB, 1'b0, 11'h0AB}, '{8'h14, 8'h3F, 1'b0, 11'h03F}, '{8'h12, 8'h7E, 1'b0, 11'h47E},
    '{8'h16, 8'hFC, 1'b0, 11'h0FC}, '{8'h11, 8'h5A, 1'b0, 11'h05A}, '{8'h13, 8'hC3, 1'b0, 11'h4C3},
    '{8'h30, 8'h96, 1'b0, 11'h096}, '{8'h10, 8'h11, 1'b1, 11'h011}, '{8'h10, 8'h22, 1'b0, 11'h022}};
  always #50 ref_clk = ~ref_clk;
  sbfp_top dut_u (
    .ref_clk(ref_clk), .nrst(nrst), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .sclk_in(sclk_in), .rxd_in(rxd_in), .txd_out(txd_out), .txd_oe(txd_oe));
  sbfp_remote rem_u (.sclk(sclk_in), .rxd(rxd_in), .txd_wire(txd_wire));
  // ==========
  // checking and bus tasks
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask
  task automatic bus(input logic [7:0] a, input bit w, input logic [31:0] d);
    int t;
    @(posedge ref_clk);
    avs_address <= a;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= d;
    t = 0;
    do begin
      @(posedge ref_clk);
      t++;
    end while (avs_waitrequest !== 1'b0 && t < 50);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    cmp(t < 50, 1, "bus answer");
  endtask
  // ==========
  // frame builder: check register runs over content bits only
  // zero after five content ones
  task automatic put(input logic [15:0] v, input int n, input bit msb);
    bit b;
    for (int i = 0; i < n; i++) begin
      b = msb ? v[n - 1 - i] : v[i];
      fr.push_back(b);
      if (!msb) crc = {crc[14:0], 1'b0} ^ ((crc[15] ^ b) ? `SBFP_CRC_POLY : 16'h0000);
      ones = b ? ones + 1 : 0;
      if (ones == 5) begin
        fr.push_back(1'b0);
        ones = 0;
      end
    end
  endtask
  task automatic flag();
    for (int i = 0; i < 8; i++) fr.push_back(i != 0 && i != 7);
    ones = 0;
  endtask
  task automatic build(input logic [7:0] d, input bit fcs, input bit bad);
    fr.delete();
    crc = `SBFP_CRC_PRESET;
    flag();
    put({8'h00, d}, 8, 1'b0);
    if (fcs) put(crc ^ {15'h0, bad}, 16, 1'b1);
    flag();
  endtask
  task automatic report_and_stop();
    if (n_fail == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // ==========
  // watchdog: the whole sequence needs well under one millisecond
  initial begin
    #2_000_000;
    n_fail++;
    $display("unexpected at %0t: watchdog expired", $time);
    report_and_stop();
  end
  // ==========
  // main sequence
  initial begin
    repeat (20) @(posedge ref_clk);
    nrst <= 1'b1;
    foreach (rows[i]) begin
      bus(`SBFP_OFS_CTRL, 1, {24'h00_0000, rows[i].ctrl});
      build(rows[i].d, !rows[i].ctrl[0], rows[i].bad);
      rem_u.q_out = fr;
      rem_u.run(fr.size(), rows[i].ctrl[5]);
      bus(`SBFP_OFS_STAT, 0, 0);
      cmp(rd[1], rows[i].bad, "check error flag");
      bus(`SBFP_OFS_RXD, 0, 0);
      if (!rows[i].bad) cmp(rd, {21'h0, rows[i].rx}, "received byte");
      bus(`SBFP_OFS_STAT, 1, {19'h0, `SBFP_ST_W1C});
    end
    bus(`SBFP_OFS_CTRL, 1, 32'h0000_0011);
    // shutoff and abort inside the frame, then early go-ahead and go-ahead while hunting
    rem_u.q_out = '{0,0,0,0,0,0,0,0, 1,1,1,1,1,1,1, 0,1,1,1,1,1,0, 1,1,1,1,1,1,1};
    rem_u.run(50, 0);
    bus(`SBFP_OFS_STAT, 0, 0);
    cmp(rd & 32'h0000_0078, 32'h0000_0078, "pattern flags");
    bus(`SBFP_OFS_STAT, 1, {19'h0, `SBFP_ST_W1C});
    bus(`SBFP_OFS_STAT, 0, 0);
    cmp(rd & 32'h0000_0078, 0, "pattern flags cleared");
    for (int k = 0; k < 2; k++) begin
      bus(`SBFP_OFS_TXD, 1, 32'h0000_01F8);
      bus(`SBFP_OFS_CTRL, 1, k ? 32'h0000_0009 : 32'h0000_0008);
      build(8'hF8, !k, 1'b0);
      rem_u.q_in.delete();
      rem_u.run(fr.size() + 12, 0);
      while (rem_u.q_in.size() > 1 && rem_u.q_in[0]) void'(rem_u.q_in.pop_front());
      cmp(rem_u.q_in.size() >= fr.size(), 1, "tx length");
      foreach (fr[j]) cmp(rem_u.q_in[j], fr[j], "tx bit");
    end
    bus(`SBFP_OFS_PORT3, 1, 32'h0000_0000);
    repeat (2) @(posedge ref_clk);
    cmp(txd_oe, 0, "pin enable in diag");
    bus(`SBFP_OFS_STAT, 0, 0);
    cmp(rd[12], 1, "diag flag");
    bus(`SBFP_OFS_CTRL, 1, 32'h0000_0001);
    build(8'h5C, 1'b0, 1'b0);
    foreach (fr[j]) bus(`SBFP_OFS_PORT3, 1, {31'h0, fr[j]});
    bus(`SBFP_OFS_RXD, 0, 0);
    cmp(rd, 32'h0000_005C, "diag byte");
    bus(`SBFP_OFS_PORT3, 0, 0);
    cmp(rd, 32'h0000_0002, "diag line readback");
    bus(`SBFP_OFS_PORT3, 1, 32'h0000_0003);
    repeat (2) @(posedge ref_clk);
    cmp(txd_oe, 1, "pin enable after diag");
    bus(`SBFP_OFS_CTRL, 1, 32'hFFFF_FFFF);
    bus(`SBFP_OFS_CTRL, 0, 0);
    cmp(rd, 32'h0000_003F, "control width");
    nrst <= 1'b0;
    repeat (4) @(posedge ref_clk);
    nrst <= 1'b1;
    foreach (rst_a[j]) begin
      bus(rst_a[j], 0, 0);
      cmp(rd, rst_v[j], "reset value");
    end
    report_and_stop();
  end
endmodule // sbfp_top_test
`default_nettype wire
